// ===== hdl/fpes_pkg.sv
package fpes_pkg;

  // Opcodes, both codes of each A/B pair mean the same operation
  localparam logic [7:0] OPC_EXT_PROG_A   = 8'hc2;
  localparam logic [7:0] OPC_EXT_PROG_B   = 8'h3e;
  localparam logic [7:0] OPC_SECT_A       = 8'h20;
  localparam logic [7:0] OPC_SECT_B       = 8'h21;
  localparam logic [7:0] OPC_HALF_A       = 8'h52;
  localparam logic [7:0] OPC_HALF_B       = 8'h5c;
  localparam logic [7:0] OPC_FULL_A       = 8'hd8;
  localparam logic [7:0] OPC_FULL_B       = 8'hdc;
  localparam logic [7:0] OPC_CHIP_A       = 8'h60;
  localparam logic [7:0] OPC_CHIP_B       = 8'hc7;
  localparam logic [7:0] OPC_FOUR_WIRE_ON = 8'h38;
  localparam logic [7:0] OPC_FOUR_WIRE_OFF = 8'hff;
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;

  // Address bytes minus one, per address mode
  localparam logic [2:0] LAST_ABYTE_3 = 3'h2;
  localparam logic [2:0] LAST_ABYTE_4 = 3'h3;

  // Status byte layout
  localparam int ST_WIP_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LSB  = 2;

  // Protection: 64KB blocks in the array, level that covers all of them
  localparam logic [9:0] BLOCK_COUNT    = 10'h200;
  localparam logic [3:0] PROT_ALL_LEVEL = 4'ha;

  // Self-timed durations in microseconds, clock in MHz
  localparam longint unsigned CLK_MHZ                  = 125;
  localparam longint unsigned PROGRAM_TIME_US          = 400;
  localparam longint unsigned SECTOR_ERASE_TIME_US     = 50000;
  localparam longint unsigned HALF_BLOCK_ERASE_TIME_US = 150000;
  localparam longint unsigned FULL_BLOCK_ERASE_TIME_US = 200000;
  localparam longint unsigned WHOLE_ARRAY_ERASE_TIME_US = 20000000;

  // Reset value of the synchronised pins: select high, clock low
  localparam logic [5:0] PINS_RST = 6'h20;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_PROGRAM = 3'b001,
    OP_SECTOR  = 3'b010,
    OP_HALF    = 3'b011,
    OP_FULL    = 3'b100,
    OP_CHIP    = 3'b101
  } fpes_kind_t;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } fpes_pins_t;

  typedef struct packed {
    fpes_kind_t  kind;
    logic [31:0] addr;
  } fpes_op_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
  } fpes_wr_t;

endpackage : fpes_pkg

// ===== hdl/fpes_sync.sv
module fpes_sync #(
  parameter int         W       = 6,
  parameter logic [5:0] RST_VAL = 6'h20
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_r  <= RST_VAL[W-1:0];
      s2_r  <= RST_VAL[W-1:0];
      s3_r  <= RST_VAL[W-1:0];
      q_out <= RST_VAL[W-1:0];
    end
    else
    begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit changes only once the second and third stages agree
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
        begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : fpes_sync

// ===== hdl/fpes_page_mem.sv
module fpes_page_mem (
  input  wire logic       clk_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [7:0] rd_addr_in,
  output logic      [7:0] rd_data_out
);

  logic [7:0] mem [256];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule : fpes_page_mem

// ===== hdl/fpes_top.sv
module fpes_top
  import fpes_pkg::*;
#(
  parameter logic [31:0] PROG_CYCLES  = 32'(PROGRAM_TIME_US * CLK_MHZ),
  parameter logic [31:0] SECT_CYCLES  = 32'(SECTOR_ERASE_TIME_US * CLK_MHZ),
  parameter logic [31:0] HALF_CYCLES  = 32'(HALF_BLOCK_ERASE_TIME_US * CLK_MHZ),
  parameter logic [31:0] FULL_CYCLES  = 32'(FULL_BLOCK_ERASE_TIME_US * CLK_MHZ),
  parameter logic [31:0] WHOLE_CYCLES = 32'(WHOLE_ARRAY_ERASE_TIME_US * CLK_MHZ)
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             select_n_in,
  input  wire logic             serial_clock_in,
  input  wire logic [3:0]       quad_line_in,
  output logic      [3:0]       quad_line_out,
  output logic      [3:0]       quad_line_oe_out,
  input  wire logic [4:0]       protect_bits_in,
  input  wire logic             four_byte_mode_in,
  input  wire logic             write_enable_set_in,
  output logic                  write_enable_latch_out,
  output logic                  write_in_progress_out,
  output logic                  four_wire_command_mode_out,
  output logic                  op_start_out,
  output fpes_pkg::fpes_op_t    op_out,
  output logic                  array_wr_out,
  output fpes_pkg::fpes_wr_t    array_wr_data_out
);
  import fpes_pkg::*;

  typedef enum logic [2:0] {
    ST_OPC  = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_STAT = 3'b011,
    ST_DONE = 3'b100,
    ST_DROP = 3'b101
  } fpes_st_t;

  fpes_pins_t  pins_raw;
  fpes_pins_t  pins;
  fpes_st_t    st_r;
  fpes_kind_t  kind_r;
  logic        sclk_prev_r;
  logic        cs_prev_r;
  logic [7:0]  sh_r;
  logic [2:0]  bits_r;
  logic [7:0]  opc_r;
  logic [2:0]  abytes_r;
  logic [31:0] addr_r;
  logic [7:0]  pos_r;
  logic        got_data_r;
  logic [255:0] mask_r;
  logic        wel_r;
  logic        wip_r;
  logic        qpi_r;
  logic [31:0] cnt_r;
  logic        sweep_r;
  logic [7:0]  sweep_idx_r;
  logic        rd_vld_r;
  logic [7:0]  rd_idx_r;
  logic [7:0]  rd_data;
  logic [7:0]  stat_sh_r;
  logic [2:0]  stat_cnt_r;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  logic        wide;
  logic [3:0]  bits_nxt;
  logic [7:0]  sh_nxt;
  logic        byte_done;
  logic        exec_ok;
  logic        prot_hit;
  logic        launch;
  logic        data_wr;
  logic [7:0]  status_now;

  assign pins_raw = '{cs_n: select_n_in, sclk: serial_clock_in, io: quad_line_in};

  fpes_sync #(.W(6), .RST_VAL(PINS_RST)) u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (pins_raw),
    .q_out   (pins)
  );

  fpes_page_mem u_page (
    .clk_in      (clk_in),
    .wr_en_in    (data_wr),
    .wr_addr_in  (pos_r),
    .wr_data_in  (sh_nxt),
    .rd_addr_in  (sweep_idx_r),
    .rd_data_out (rd_data)
  );

  function automatic fpes_kind_t kind_of(input logic [7:0] opc);
    unique case (opc)
      OPC_EXT_PROG_A, OPC_EXT_PROG_B: kind_of = OP_PROGRAM;
      OPC_SECT_A, OPC_SECT_B:         kind_of = OP_SECTOR;
      OPC_HALF_A, OPC_HALF_B:         kind_of = OP_HALF;
      OPC_FULL_A, OPC_FULL_B:         kind_of = OP_FULL;
      OPC_CHIP_A, OPC_CHIP_B:         kind_of = OP_CHIP;
      default:                        kind_of = OP_NONE;
    endcase
  endfunction : kind_of

  // Protected 64KB blocks sit at the top, or at the bottom when bit 4 is set
  function automatic logic is_protected(input logic [4:0] bp, input logic [31:0] a);
    logic [9:0] n;
    logic [9:0] blk;
    n   = '0;
    blk = {1'b0, a[24:16]};
    if (bp[3:0] >= PROT_ALL_LEVEL)
      n = BLOCK_COUNT;
    else if (bp[3:0] != 4'h0)
      n = 10'(10'h1 << (bp[3:0] - 4'h1));
    if (bp[4])
      is_protected = blk < n;
    else
      is_protected = (n != 10'h0) && (blk >= BLOCK_COUNT - n);
  endfunction : is_protected

  function automatic logic [31:0] duration(input fpes_kind_t k);
    unique case (k)
      OP_PROGRAM: duration = PROG_CYCLES;
      OP_SECTOR:  duration = SECT_CYCLES;
      OP_HALF:    duration = HALF_CYCLES;
      OP_FULL:    duration = FULL_CYCLES;
      OP_CHIP:    duration = WHOLE_CYCLES;
      default:    duration = 32'h1;
    endcase
  endfunction : duration

  assign rise      = pins.sclk & ~sclk_prev_r & ~pins.cs_n;
  assign fall      = ~pins.sclk & sclk_prev_r & ~pins.cs_n;
  assign cs_rise   = pins.cs_n & ~cs_prev_r;
  assign wide      = qpi_r | (st_r == ST_DATA);
  assign bits_nxt  = {1'b0, bits_r} + (wide ? 4'h4 : 4'h1);
  assign sh_nxt    = wide ? {sh_r[3:0], pins.io} : {sh_r[6:0], pins.io[0]};
  assign byte_done = rise & bits_nxt[3];
  assign data_wr   = byte_done & (st_r == ST_DATA);
  // Only whole bytes, and for a program at least one data byte, may execute
  assign exec_ok   = (bits_r == 3'h0) &&
                     ((st_r == ST_DONE) || (st_r == ST_DATA && got_data_r));
  assign prot_hit  = (kind_r == OP_CHIP) ? (protect_bits_in != 5'h0)
                                         : is_protected(protect_bits_in, addr_r);
  assign launch    = cs_rise & exec_ok & (kind_r != OP_NONE) & ~prot_hit;
  assign status_now = {1'b0, protect_bits_in, wel_r, wip_r};

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sclk_prev_r <= 1'b0;
      cs_prev_r   <= 1'b1;
    end
    else
    begin
      sclk_prev_r <= pins.sclk;
      cs_prev_r   <= pins.cs_n;
    end
  end

  // Command framing
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_r       <= ST_OPC;
      kind_r     <= OP_NONE;
      sh_r       <= 8'h00;
      bits_r     <= 3'h0;
      opc_r      <= 8'h00;
      abytes_r   <= 3'h0;
      addr_r     <= 32'h0;
      pos_r      <= 8'h00;
      got_data_r <= 1'b0;
      mask_r     <= '0;
    end
    else if (pins.cs_n)
    begin
      st_r   <= ST_OPC;
      bits_r <= 3'h0;
    end
    else if (rise)
    begin
      bits_r <= bits_nxt[2:0];
      sh_r   <= sh_nxt;
      if (st_r == ST_DONE)
      begin
        st_r <= ST_DROP;
      end
      else if (byte_done)
      begin
        unique case (st_r)
          ST_OPC:
          begin
            opc_r      <= sh_nxt;
            kind_r     <= kind_of(sh_nxt);
            abytes_r   <= 3'h0;
            addr_r     <= 32'h0;
            got_data_r <= 1'b0;
            // A status poll while busy must keep the mask that the page sweep reads
            if (!wip_r)
              mask_r <= '0;
            if (sh_nxt == OPC_READ_STATUS)
              st_r <= ST_STAT;
            else if (wip_r)
              st_r <= ST_DROP;
            else if (kind_of(sh_nxt) == OP_CHIP)
              st_r <= wel_r ? ST_DONE : ST_DROP;
            else if (kind_of(sh_nxt) != OP_NONE)
              st_r <= wel_r ? ST_ADDR : ST_DROP;
            else if (sh_nxt == OPC_FOUR_WIRE_ON && !qpi_r)
              st_r <= ST_DONE;
            else if (sh_nxt == OPC_FOUR_WIRE_OFF && qpi_r)
              st_r <= ST_DONE;
            else
              st_r <= ST_DROP;
          end
          ST_ADDR:
          begin
            addr_r   <= {addr_r[23:0], sh_nxt};
            abytes_r <= abytes_r + 3'h1;
            pos_r    <= sh_nxt;
            if (abytes_r == (four_byte_mode_in ? LAST_ABYTE_4 : LAST_ABYTE_3))
              st_r <= (kind_r == OP_PROGRAM) ? ST_DATA : ST_DONE;
          end
          ST_DATA:
          begin
            // Later bytes overwrite earlier ones at the same page offset
            pos_r         <= pos_r + 8'h01;
            mask_r[pos_r] <= 1'b1;
            got_data_r    <= 1'b1;
          end
          default:
          begin
            st_r <= st_r;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      qpi_r <= 1'b0;
    else if (cs_rise && exec_ok && opc_r == OPC_FOUR_WIRE_ON)
      qpi_r <= 1'b1;
    else if (cs_rise && exec_ok && opc_r == OPC_FOUR_WIRE_OFF)
      qpi_r <= 1'b0;
  end

  // Latch: a set from the enable decoder wins over the clear at launch
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      wel_r <= 1'b0;
    else if (write_enable_set_in)
      wel_r <= 1'b1;
    else if (launch)
      wel_r <= 1'b0;
  end

  // Self-timed cycle
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wip_r        <= 1'b0;
      cnt_r        <= 32'h0;
      op_start_out <= 1'b0;
      op_out       <= '{kind: OP_NONE, addr: 32'h0};
    end
    else
    begin
      op_start_out <= launch;
      if (launch)
      begin
        wip_r  <= 1'b1;
        cnt_r  <= duration(kind_r) - 32'h1;
        op_out <= '{kind: kind_r, addr: addr_r};
      end
      else if (wip_r)
      begin
        if (cnt_r == 32'h0)
          wip_r <= 1'b0;
        else
          cnt_r <= cnt_r - 32'h1;
      end
    end
  end

  // Page sweep: only received bytes go to the array
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sweep_r           <= 1'b0;
      sweep_idx_r       <= 8'h00;
      rd_vld_r          <= 1'b0;
      rd_idx_r          <= 8'h00;
      array_wr_out      <= 1'b0;
      array_wr_data_out <= '{addr: 32'h0, data: 8'h00};
    end
    else
    begin
      if (launch && kind_r == OP_PROGRAM)
      begin
        sweep_r     <= 1'b1;
        sweep_idx_r <= 8'h00;
      end
      else if (sweep_r)
      begin
        sweep_idx_r <= sweep_idx_r + 8'h01;
        sweep_r     <= sweep_idx_r != 8'hff;
      end
      rd_vld_r          <= sweep_r & mask_r[sweep_idx_r];
      rd_idx_r          <= sweep_idx_r;
      array_wr_out      <= rd_vld_r;
      array_wr_data_out <= '{addr: {op_out.addr[31:8], rd_idx_r}, data: rd_data};
    end
  end

  // Status answer, live value reloaded every byte
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stat_sh_r        <= 8'h00;
      stat_cnt_r       <= 3'h0;
      quad_line_out    <= 4'h0;
      quad_line_oe_out <= 4'h0;
    end
    else if (pins.cs_n || st_r != ST_STAT)
    begin
      stat_cnt_r       <= 3'h0;
      quad_line_oe_out <= 4'h0;
    end
    else if (fall)
    begin
      if (qpi_r)
      begin
        quad_line_out    <= (stat_cnt_r == 3'h0) ? status_now[7:4] : stat_sh_r[7:4];
        quad_line_oe_out <= 4'hf;
        stat_sh_r        <= (stat_cnt_r == 3'h0) ? {status_now[3:0], 4'h0}
                                                 : {stat_sh_r[3:0], 4'h0};
        stat_cnt_r       <= stat_cnt_r + 3'h4;
      end
      else
      begin
        quad_line_out    <= {2'b00, (stat_cnt_r == 3'h0) ? status_now[7] : stat_sh_r[7], 1'b0};
        quad_line_oe_out <= 4'h2;
        stat_sh_r        <= (stat_cnt_r == 3'h0) ? {status_now[6:0], 1'b0}
                                                 : {stat_sh_r[6:0], 1'b0};
        stat_cnt_r       <= stat_cnt_r + 3'h1;
      end
    end
  end

  assign write_enable_latch_out     = wel_r;
  assign write_in_progress_out      = wip_r;
  assign four_wire_command_mode_out = qpi_r;

  a_busy_on_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_start_out |-> write_in_progress_out [*8])
    else $error("busy not held after start");
  a_latch_cleared: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_start_out && !$past(write_enable_set_in) |-> !write_enable_latch_out)
    else $error("latch not cleared at start");
  a_latch_needed: assert property (@(posedge clk_in) disable iff (!nrst_in)
    launch |-> wel_r && !wip_r)
    else $error("launch without latch");
  a_chip_unprot: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_start_out && op_out.kind == OP_CHIP |-> $past(protect_bits_in) == 5'h0)
    else $error("chip erase while protected");
  a_busy_no_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(write_in_progress_out) |-> !op_start_out)
    else $error("start during busy cycle");
  a_mode_keeps_wel: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $changed(qpi_r) && !$past(write_enable_set_in) |-> $stable(wel_r))
    else $error("mode change altered latch");
  a_page_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
    array_wr_out |-> array_wr_data_out.addr[31:8] == op_out.addr[31:8])
    else $error("write left the page");
  a_addr_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
    st_r == ST_ADDR && byte_done && !four_byte_mode_in |-> abytes_r <= 3'h2)
    else $error("too many address bytes");
  a_stat_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
    st_r == ST_STAT && pins.cs_n |=> quad_line_oe_out == 4'h0)
    else $error("status drive not released");
  a_partial_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
    cs_rise && bits_r != 3'h0 |=> !op_start_out)
    else $error("partial byte executed");

endmodule : fpes_top

// ===== verification/fpes_host_model.sv
module fpes_host_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] io_in,
  output logic            select_n_out,
  output logic            sclk_out,
  output logic      [3:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    select_n_out = 1'b1;
    sclk_out     = 1'b0;
    io_out       = 4'h0;
  end

  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask : half

  // Data changes while the clock is low, the device samples on the rise
  task automatic tick(input logic [3:0] v);
    sclk_out = 1'b0;
    io_out   = v;
    half();
    sclk_out = 1'b1;
    half();
  endtask : tick

  task automatic send_byte(input logic [7:0] b, input logic quad);
    if (quad)
    begin
      tick(b[7:4]);
      tick(b[3:0]);
    end
    else
      for (int i = 7; i >= 0; i--)
        tick({{3{~b[i]}}, b[i]});
  endtask : send_byte

  task automatic open_frame();
    select_n_out = 1'b0;
    half();
  endtask : open_frame

  // Clock parks low; the released lines show the inverse of their last value
  task automatic close_frame();
    sclk_out = 1'b0;
    half();
    select_n_out = 1'b1;
    io_out       = ~io_out;
    half();
  endtask : close_frame

  task automatic read_status(output logic [7:0] s);
    open_frame();
    send_byte(8'h05, 1'b0);
    for (int i = 7; i >= 0; i--)
    begin
      tick(~io_out);
      s[i] = io_in[1];
    end
    close_frame();
  endtask : read_status
endmodule : fpes_host_model

// ===== verification/tb.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpes_pkg::*;

  localparam logic [31:0] CYC = 32'h258;

  logic            clk;
  logic            nrst;
  logic            four_b;
  logic            wes;
  logic            sel_n;
  logic            sclk;
  logic      [4:0] prot;
  logic      [3:0] h_io;
  logic      [3:0] d_io;
  logic      [3:0] d_oe;
  wire       [3:0] io_w;
  logic            write_enable_latch;
  logic            write_in_progress;
  logic            fw;
  logic            start;
  logic            wr;
  fpes_op_t        op;
  fpes_op_t        last_op;
  fpes_wr_t        wrd;
  logic      [7:0] pmem [256];
  logic      [7:0] st;
  logic      [7:0] ops [8] = '{OPC_SECT_A, OPC_SECT_B, OPC_HALF_A, OPC_HALF_B,
                               OPC_FULL_A, OPC_FULL_B, OPC_CHIP_A, OPC_CHIP_B};
  int              failures;
  int              checked;
  int              starts;
  int              writes;

  assign io_w = (d_oe & d_io) | (~d_oe & h_io);

  fpes_top #(.PROG_CYCLES(CYC), .SECT_CYCLES(CYC), .HALF_CYCLES(CYC),
             .FULL_CYCLES(CYC), .WHOLE_CYCLES(CYC)) u_fpes_top (
    .clk_in                     (clk),
    .nrst_in                    (nrst),
    .select_n_in                (sel_n),
    .serial_clock_in            (sclk),
    .quad_line_in               (io_w),
    .quad_line_out              (d_io),
    .quad_line_oe_out           (d_oe),
    .protect_bits_in            (prot),
    .four_byte_mode_in          (four_b),
    .write_enable_set_in        (wes),
    .write_enable_latch_out     (write_enable_latch),
    .write_in_progress_out      (write_in_progress),
    .four_wire_command_mode_out (fw),
    .op_start_out               (start),
    .op_out                     (op),
    .array_wr_out               (wr),
    .array_wr_data_out          (wrd)
  );

  fpes_host_model u_fpes_host_model (
    .clk_in       (clk),
    .io_in        (io_w),
    .select_n_out (sel_n),
    .sclk_out     (sclk),
    .io_out       (h_io)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (start === 1'b1)
    begin
      starts++;
      last_op = op;
    end
    if (wr === 1'b1)
    begin
      writes++;
      pmem[wrd.addr[7:0]] = wrd.data;
    end
  end

  task automatic stop_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic set_wel();
    @(negedge clk) wes = 1'b1;
    @(negedge clk) wes = 1'b0;
  endtask : set_wel

  // Opcode, na address bytes, nd quad data bytes, then extra stray clocks
  task automatic cmd(input logic [7:0] opc, input logic [31:0] a, input int na,
                     input int nd, input int extra);
    starts = 0;
    writes = 0;
    u_fpes_host_model.open_frame();
    u_fpes_host_model.send_byte(opc, fw);
    for (int i = na - 1; i >= 0; i--)
      u_fpes_host_model.send_byte(a[8*i+:8], fw);
    for (int j = 0; j < nd; j++)
      u_fpes_host_model.send_byte(8'(j) + 8'(j / 256) * 8'h55, 1'b1);
    repeat (extra) u_fpes_host_model.tick(4'h0);
    u_fpes_host_model.close_frame();
    repeat (20) @(negedge clk);
  endtask : cmd

  task automatic expect_op(input int n, input fpes_kind_t k, input logic [31:0] a);
    `CHK(starts, n)
    if (n > 0)
    begin
      `CHK(last_op.kind, k)
      if (k != OP_CHIP) `CHK(last_op.addr, a)
      `CHK(write_enable_latch, 1'b0)
      `CHK(write_in_progress, 1'b1)
      if (fw !== 1'b1)
      begin
        u_fpes_host_model.read_status(st);
        `CHK(st[ST_WIP_BIT], 1'b1)
        `CHK(st[ST_BP_LSB+:5], prot)
      end
      for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++) @(negedge clk);
      `CHK(write_in_progress, 1'b0)
    end
  endtask : expect_op

  initial
  begin
    #400us;
    failures++;
    stop_test();
  end

  initial
  begin
    nrst   = 1'b0;
    prot   = 5'h00;
    four_b = 1'b0;
    wes    = 1'b0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    cmd(OPC_SECT_A, 32'h00012345, 3, 0, 0);
    expect_op(0, OP_NONE, 0);
    $display("test latch_clear done");
    for (int i = 0; i < 8; i++)
    begin
      set_wel();
      cmd(ops[i], 32'h00012345, i < 6 ? 3 : 0, 0, 0);
      expect_op(1, fpes_kind_t'(3'(i / 2 + 2)), 32'h00012345);
    end
    $display("test erase_codes done");
    set_wel();
    cmd(OPC_SECT_B, 32'h00012345, 3, 0, 1);
    expect_op(0, OP_NONE, 0);
    cmd(OPC_CHIP_A, 0, 0, 0, 3);
    expect_op(0, OP_NONE, 0);
    cmd(OPC_EXT_PROG_A, 32'h000100f0, 3, 4, 1);
    expect_op(0, OP_NONE, 0);
    $display("test framing done");
    cmd(OPC_EXT_PROG_A, 32'h000100f0, 3, 20, 0);
    expect_op(1, OP_PROGRAM, 32'h000100f0);
    `CHK(writes, 20)
    `CHK(pmem[8'hf0], 8'h00)
    `CHK(pmem[8'h03], 8'h13)
    set_wel();
    cmd(OPC_EXT_PROG_B, 32'h00020000, 3, 258, 0);
    expect_op(1, OP_PROGRAM, 32'h00020000);
    `CHK(writes, 256)
    `CHK(pmem[8'h00], 8'h55)
    `CHK(pmem[8'h01], 8'h56)
    `CHK(pmem[8'h02], 8'h02)
    $display("test program done");
    four_b = 1'b1;
    prot   = 5'h01;
    set_wel();
    cmd(OPC_SECT_A, 32'h01ff8000, 4, 0, 0);
    expect_op(0, OP_NONE, 0);
    cmd(OPC_EXT_PROG_A, 32'h01ff8000, 4, 1, 0);
    expect_op(0, OP_NONE, 0);
    cmd(OPC_CHIP_B, 0, 0, 0, 0);
    expect_op(0, OP_NONE, 0);
    cmd(OPC_HALF_A, 32'h01fe8000, 4, 0, 0);
    expect_op(1, OP_HALF, 32'h01fe8000);
    four_b = 1'b0;
    prot   = 5'h00;
    $display("test protect done");
    set_wel();
    cmd(OPC_FOUR_WIRE_ON, 0, 0, 0, 0);
    `CHK(fw, 1'b1)
    `CHK(write_enable_latch, 1'b1)
    cmd(OPC_FULL_B, 32'h00030000, 3, 0, 0);
    expect_op(1, OP_FULL, 32'h00030000);
    set_wel();
    cmd(OPC_FOUR_WIRE_OFF, 0, 0, 0, 0);
    `CHK(fw, 1'b0)
    `CHK(write_enable_latch, 1'b1)
    $display("test four_wire done");
    stop_test();
  end
endmodule : tb
